/* File: logic/flpc_regs.sv */
`timescale 1ns/1ns
// How it works
// - Summary register bit 0 is OR of latched flags; bits 15:1 read zero.
// - Reading the summary leaves all latched flags untouched.
// - Fourteen flags latch when fault occurs with enable set; bits 15:14 zero.
// - Writing an enable bit to 0 clears its latched flag immediately.
// - Reading the latched register returns flags then clears all fourteen.
// - After a clearing read, flags with fault and enable still present set again.
// - Pin zero config 00 shows supplies ok, 01 its complement.
// - Pin zero config 10 open-drain mirrors written bit; 11 is an input.
// - Pin one config 00 shows DAC fault (code 00 or ff), 01 complement.
// - Pin one config 10 open-drain mirrors written bit; 11 is an input.
// - Strap high at power-on clears both general pin bits, driving both low.
// - Bit 6 reads the current alert pin level, read only.
// - Alert disable 1 never asserts; 0 drives alert low on any latched flag.
// - Test bit 8 stops ADC result updates and lets the host write them.
// - Writing 1 to bit 10 starts tracking; reads 1 while pending, else zero.
// - A flag can set only while enabled; disabled flags always read zero.
// - Instantaneous faults are unlatched and use the same fourteen-bit order.
module flpc_regs
  import flpc_pkg::*;
#(
  parameter bit HAS_TRACKING = 1'b1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  input wire logic [13:0] inst_fault,
  input wire logic [7:0] dac0_code,
  input wire logic [7:0] dac1_code,
  input wire logic tracking_pending,
  output logic tracking_launch,
  output logic adc_result_host_write_test,
  input wire logic pin_zero_i,
  output logic pin_zero_o,
  output logic pin_zero_oe,
  input wire logic pin_one_i,
  output logic pin_one_o,
  output logic pin_one_oe,
  input wire logic alert_n_i,
  output logic alert_n_o,
  output logic alert_n_oe,
  input wire logic strap_i
);
  initial begin
    if (FLPC_NFLT != 14) $error("flpc_regs serves exactly fourteen fault flags");
  end

  logic [13:0] latched_q, latched_d;
  logic [13:0] enable_q, enable_d;
  logic [1:0] pin_zero_config_q, pin_one_config_q;
  logic pin_zero_wr_q, pin_one_wr_q;
  logic alert_disable_q, test_q;
  logic [1:0] strap_cnt_q;
  logic [15:0] rdata_q;
  logic rvalid_q, launch_q;
  logic pin_zero_oe_q, pin_one_oe_q, alert_oe_q;
  logic [3:0] pins_sync;

  // Pin levels come through the two-flop synchroniser
  flpc_sync #(.W(4)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_i({strap_i, alert_n_i, pin_one_i, pin_zero_i}),
    .sync_o(pins_sync)
  );

  wire pin_zero_lvl = pins_sync[0];
  wire pin_one_lvl = pins_sync[1];
  wire alert_pin_level = pins_sync[2];
  wire strap_pin_level = pins_sync[3];

  // Command decode
  wire wr_enable = cmd_wr && (cmd_code == FLPC_CMD_ENABLE);
  wire wr_pinctl = cmd_wr && (cmd_code == FLPC_CMD_PINCTL);
  wire rd_latched = cmd_rd && (cmd_code == FLPC_CMD_LATCHED);
  wire strap_apply = (strap_cnt_q == FLPC_STRAP_WAIT - 2'h1) && strap_pin_level;

  // Status terms
  wire any_latched_fault = |latched_q;
  wire supplies_ok = ~|(inst_fault & FLPC_SUPPLY_MASK);
  wire dac_fault = (dac0_code == FLPC_DAC_LOW) || (dac0_code == FLPC_DAC_HIGH) ||
                   (dac1_code == FLPC_DAC_LOW) || (dac1_code == FLPC_DAC_HIGH);

  // Enable register, write takes effect in the same edge as the flag mask
  assign enable_d = wr_enable ? cmd_wdata[13:0] : enable_q;
  // Read clears, set wins, and new enable masks at once
  assign latched_d = ((rd_latched ? 14'h0000 : latched_q) | (inst_fault & enable_q)) & enable_d;

  // Pin register bit values per configuration
  logic pin_zero_value, pin_one_value;
  always_comb begin
    case (pin_zero_config_q)
      FLPC_CFG_STATUS: pin_zero_value = supplies_ok;
      FLPC_CFG_STATUS_N: pin_zero_value = ~supplies_ok;
      FLPC_CFG_OUTPUT: pin_zero_value = pin_zero_wr_q;
      default: pin_zero_value = pin_zero_lvl;
    endcase
    case (pin_one_config_q)
      FLPC_CFG_STATUS: pin_one_value = dac_fault;
      FLPC_CFG_STATUS_N: pin_one_value = ~dac_fault;
      FLPC_CFG_OUTPUT: pin_one_value = pin_one_wr_q;
      default: pin_one_value = pin_one_lvl;
    endcase
  end

  // Open drain pulls low when value is 0, released in input mode
  wire pin_zero_oe_d = (pin_zero_config_q != FLPC_CFG_INPUT) && !pin_zero_value;
  wire pin_one_oe_d = (pin_one_config_q != FLPC_CFG_INPUT) && !pin_one_value;
  wire alert_oe_d = !alert_disable_q && any_latched_fault;
  wire track_rd = HAS_TRACKING && tracking_pending;

  // Pin control readback
  logic [15:0] pinctl_rd;
  always_comb begin
    pinctl_rd = 16'h0000;
    pinctl_rd[FLPC_CFG0_LSB +: 2] = pin_zero_config_q;
    pinctl_rd[FLPC_CFG1_LSB +: 2] = pin_one_config_q;
    pinctl_rd[FLPC_PIN0_BIT] = pin_zero_value;
    pinctl_rd[FLPC_PIN1_BIT] = pin_one_value;
    pinctl_rd[FLPC_ALERT_BIT] = alert_pin_level;
    pinctl_rd[FLPC_ADIS_BIT] = alert_disable_q;
    pinctl_rd[FLPC_TEST_BIT] = test_q;
    pinctl_rd[FLPC_STRAP_BIT] = strap_pin_level;
    pinctl_rd[FLPC_TRACK_BIT] = track_rd;
  end

  // Read data select
  wire [15:0] rdata_d =
    (cmd_code == FLPC_CMD_SUMMARY) ? {15'h0000, any_latched_fault} :
    (cmd_code == FLPC_CMD_LATCHED) ? {2'h0, latched_q} :
    (cmd_code == FLPC_CMD_ENABLE) ? {2'h0, enable_q} :
    (cmd_code == FLPC_CMD_PINCTL) ? pinctl_rd :
    (cmd_code == FLPC_CMD_INSTANT) ? {2'h0, inst_fault} : 16'h0000;

  // Fault latches and enables
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latched_q <= 14'h0000;
      enable_q <= FLPC_EN_RST;
    end else begin
      latched_q <= latched_d;
      enable_q <= enable_d;
    end
  end

  // Pin control register and strap capture after reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_zero_config_q <= FLPC_CFG_RST;
      pin_one_config_q <= FLPC_CFG_RST;
      pin_zero_wr_q <= FLPC_PIN_RST;
      pin_one_wr_q <= FLPC_PIN_RST;
      alert_disable_q <= FLPC_ADIS_RST;
      test_q <= FLPC_TEST_RST;
      strap_cnt_q <= 2'h0;
    end else begin
      if (strap_cnt_q != FLPC_STRAP_WAIT) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
      if (strap_apply) begin
        pin_zero_wr_q <= 1'b0;
        pin_one_wr_q <= 1'b0;
      end else if (wr_pinctl) begin
        pin_zero_wr_q <= cmd_wdata[FLPC_PIN0_BIT];
        pin_one_wr_q <= cmd_wdata[FLPC_PIN1_BIT];
      end
      if (wr_pinctl) begin
        pin_zero_config_q <= cmd_wdata[FLPC_CFG0_LSB +: 2];
        pin_one_config_q <= cmd_wdata[FLPC_CFG1_LSB +: 2];
        alert_disable_q <= cmd_wdata[FLPC_ADIS_BIT];
        test_q <= cmd_wdata[FLPC_TEST_BIT];
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      launch_q <= 1'b0;
      pin_zero_oe_q <= 1'b0;
      pin_one_oe_q <= 1'b0;
      alert_oe_q <= 1'b0;
    end else begin
      rdata_q <= cmd_rd ? rdata_d : rdata_q;
      rvalid_q <= cmd_rd;
      launch_q <= HAS_TRACKING && wr_pinctl && cmd_wdata[FLPC_TRACK_BIT];
      pin_zero_oe_q <= pin_zero_oe_d;
      pin_one_oe_q <= pin_one_oe_d;
      alert_oe_q <= alert_oe_d;
    end
  end

  assign cmd_rdata = rdata_q;
  assign cmd_rvalid = rvalid_q;
  assign tracking_launch = launch_q;
  assign adc_result_host_write_test = test_q;
  assign pin_zero_o = 1'b0;
  assign pin_one_o = 1'b0;
  assign alert_n_o = 1'b0;
  assign pin_zero_oe = pin_zero_oe_q;
  assign pin_one_oe = pin_one_oe_q;
  assign alert_n_oe = alert_oe_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  summary_read_a: assert property (cmd_rd && cmd_code == FLPC_CMD_SUMMARY |=>
    cmd_rdata == {15'h0000, |$past(latched_q)}) else $error("summary readback wrong");
  summary_keep_a: assert property (cmd_rd && cmd_code == FLPC_CMD_SUMMARY && !cmd_wr
    |=> latched_q == ($past(latched_q) | ($past(inst_fault) & $past(enable_q)))) else $error("summary read changed flags");
  flag_sets_a: assert property (|(inst_fault & enable_q) && !cmd_wr
    |=> (latched_q & $past(inst_fault & enable_q)) == $past(inst_fault & enable_q)) else $error("flag did not set");
  enable_clear_a: assert property (wr_enable |=> (latched_q & ~$past(cmd_wdata[13:0])) == 14'h0000)
    else $error("disabled flag still set");
  read_clear_a: assert property (rd_latched && !cmd_wr
    |=> latched_q == ($past(inst_fault) & $past(enable_q)) && cmd_rdata == {2'h0, $past(latched_q)})
    else $error("latched read did not clear");
  flag_masked_a: assert property (latched_q == (latched_q & enable_q)) else $error("flag set while disabled");
  alert_drive_a: assert property (!alert_disable_q && any_latched_fault
    |=> alert_n_oe) else $error("alert not driven");
  alert_quiet_a: assert property (alert_disable_q ##1 alert_disable_q |=> !alert_n_oe)
    else $error("alert driven while disabled");
  launch_pulse_a: assert property (launch_q |=> !launch_q || $past(wr_pinctl))
    else $error("tracking launch held");
endmodule // flpc_regs

/* File: logic/flpc_pkg.sv */
package flpc_pkg;
  // Command codes used on the register port
  localparam logic [7:0] FLPC_CMD_SUMMARY = 8'h00;
  localparam logic [7:0] FLPC_CMD_LATCHED = 8'h01;
  localparam logic [7:0] FLPC_CMD_ENABLE = 8'h02;
  localparam logic [7:0] FLPC_CMD_PINCTL = 8'h03;
  localparam logic [7:0] FLPC_CMD_INSTANT = 8'h04;
  // Fault vector layout
  localparam int FLPC_NFLT = 14;
  localparam logic [13:0] FLPC_SUPPLY_MASK = 14'h3f7b; // All ov/uv bits, idac bits 2 and 7 out
  localparam logic [13:0] FLPC_EN_RST = 14'h0000;
  // Pin control field positions
  localparam int FLPC_CFG0_LSB = 0;
  localparam int FLPC_CFG1_LSB = 2;
  localparam int FLPC_PIN0_BIT = 4;
  localparam int FLPC_PIN1_BIT = 5;
  localparam int FLPC_ALERT_BIT = 6;
  localparam int FLPC_ADIS_BIT = 7;
  localparam int FLPC_TEST_BIT = 8;
  localparam int FLPC_STRAP_BIT = 9;
  localparam int FLPC_TRACK_BIT = 10;
  // Pin configuration modes
  localparam logic [1:0] FLPC_CFG_STATUS = 2'h0;
  localparam logic [1:0] FLPC_CFG_STATUS_N = 2'h1;
  localparam logic [1:0] FLPC_CFG_OUTPUT = 2'h2;
  localparam logic [1:0] FLPC_CFG_INPUT = 2'h3;
  // Reset values
  localparam logic [1:0] FLPC_CFG_RST = 2'h2;
  localparam logic FLPC_PIN_RST = 1'b1;
  localparam logic FLPC_ADIS_RST = 1'b1;
  localparam logic FLPC_TEST_RST = 1'b0;
  // Strap is sampled once the two-flop synchroniser has settled
  localparam logic [1:0] FLPC_STRAP_WAIT = 2'h3;
  localparam logic [7:0] FLPC_DAC_LOW = 8'h00;
  localparam logic [7:0] FLPC_DAC_HIGH = 8'hff;
endpackage

/* File: logic/flpc_sync.sv */
`timescale 1ns/1ns
// Two-flop synchroniser for asynchronous pin levels
module flpc_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // flpc_sync

/* File: dv/flpc_pin_env.sv */
`timescale 1ns/1ns
// Board side of the three open-drain pins, each with a pull-up
module flpc_pin_env (
  input wire logic pin_zero_oe,
  input wire logic pin_one_oe,
  input wire logic alert_n_oe,
  input wire logic ext_zero_low,
  input wire logic ext_one_low,
  output logic pin_zero,
  output logic pin_one,
  output logic alert_n
);
  // A wire is low while any party pulls it, else the pull-up wins
  assign pin_zero = ~(pin_zero_oe | ext_zero_low);
  assign pin_one = ~(pin_one_oe | ext_one_low);
  assign alert_n = ~alert_n_oe;
endmodule // flpc_pin_env

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
module tb_top
  import flpc_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [15:0] cmd_rdata;
  logic cmd_rvalid;
  logic [13:0] inst_fault = 14'h0000;
  logic [7:0] dac0_code = 8'h55;
  logic [7:0] dac1_code = 8'h55;
  logic tracking_pending = 1'b0;
  logic strap = 1'b0;
  logic ext_zero_low = 1'b0;
  logic ext_one_low = 1'b0;
  logic trk, adc_test, pin_zero, pin_one, alert_n, p0_o, p1_o, al_o, p0_oe, p1_oe, al_oe;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  // Clock generator
  always #5 clk = ~clk;

  flpc_regs DUT (.clk(clk), .arst_n(arst_n), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .inst_fault(inst_fault),
    .dac0_code(dac0_code), .dac1_code(dac1_code), .tracking_pending(tracking_pending),
    .tracking_launch(trk), .adc_result_host_write_test(adc_test), .pin_zero_i(pin_zero),
    .pin_zero_o(p0_o), .pin_zero_oe(p0_oe), .pin_one_i(pin_one), .pin_one_o(p1_o), .pin_one_oe(p1_oe),
    .alert_n_i(alert_n), .alert_n_o(al_o), .alert_n_oe(al_oe), .strap_i(strap));

  flpc_pin_env env (.pin_zero_oe(p0_oe), .pin_one_oe(p1_oe), .alert_n_oe(al_oe), .ext_zero_low(ext_zero_low),
    .ext_one_low(ext_one_low), .pin_zero(pin_zero), .pin_one(pin_one), .alert_n(alert_n));

  task automatic close_out();
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
  endtask

  // Read strobe; answer stands for one cycle after the sampling edge
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    @(posedge clk);
    cmd_rd <= 1'b1;
    cmd_code <= c;
    @(posedge clk);
    cmd_rd <= 1'b0;
    #1;
    chk("rdata", e, (cmd_rvalid === 1'b1) ? cmd_rdata : ~e);
  endtask

  // One-cycle instantaneous fault
  task automatic pulse(input logic [13:0] v);
    @(posedge clk);
    inst_fault <= v;
    @(posedge clk);
    inst_fault <= 14'h0000;
  endtask

  // Cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      close_out();
    end
  end

  // Test sequence, outputs looked at one step after the edge that moves them
  initial begin
    idle(3);
    arst_n <= 1'b1;
    idle(5);
    rd(FLPC_CMD_PINCTL, 16'h00fa);
    chk("pin oe", 16'h0000, {p0_oe, p1_oe});
    chk("pin data", 16'h0000, {p0_o, p1_o, al_o});
    pulse(14'h3fff);
    rd(FLPC_CMD_LATCHED, 16'h0000);
    wr(FLPC_CMD_ENABLE, 16'h3fff);
    pulse(14'h0084);
    rd(FLPC_CMD_SUMMARY, 16'h0001);
    rd(FLPC_CMD_SUMMARY, 16'h0001);
    chk("alert oe", 16'h0000, al_oe);
    rd(FLPC_CMD_LATCHED, 16'h0084);
    rd(FLPC_CMD_LATCHED, 16'h0000);
    rd(FLPC_CMD_SUMMARY, 16'h0000);
    pulse(14'h2001);
    rd(FLPC_CMD_LATCHED, 16'h2001);
    @(posedge clk) inst_fault <= 14'h2000;
    rd(FLPC_CMD_LATCHED, 16'h2000);
    rd(FLPC_CMD_LATCHED, 16'h2000);
    rd(FLPC_CMD_INSTANT, 16'h2000);
    @(posedge clk) inst_fault <= 14'h0000;
    rd(FLPC_CMD_LATCHED, 16'h2000);
    rd(FLPC_CMD_LATCHED, 16'h0000);
    pulse(14'h0008);
    wr(FLPC_CMD_ENABLE, 16'h3ff7);
    rd(FLPC_CMD_LATCHED, 16'h0000);
    rd(FLPC_CMD_ENABLE, 16'h3ff7);
    pulse(14'h0001);
    wr(FLPC_CMD_PINCTL, 16'h007a);
    idle(4);
    #1;
    chk("alert oe", 16'h0001, al_oe);
    rd(FLPC_CMD_PINCTL, 16'h003a);
    rd(FLPC_CMD_LATCHED, 16'h0001);
    idle(4);
    #1;
    chk("alert oe", 16'h0000, al_oe);
    wr(FLPC_CMD_PINCTL, 16'h00b8);
    @(posedge clk) inst_fault <= 14'h0002;
    idle(2);
    #1;
    chk("pin0 oe", 16'h0001, p0_oe);
    rd(FLPC_CMD_PINCTL, 16'h00e8);
    wr(FLPC_CMD_PINCTL, 16'h00b9);
    idle(2);
    #1;
    chk("pin0 oe", 16'h0000, p0_oe);
    rd(FLPC_CMD_PINCTL, 16'h00f9);
    @(posedge clk) inst_fault <= 14'h0000;
    rd(FLPC_CMD_LATCHED, 16'h0002);
    wr(FLPC_CMD_PINCTL, 16'h00bb);
    ext_zero_low <= 1'b1;
    idle(4);
    rd(FLPC_CMD_PINCTL, 16'h00eb);
    chk("pin0 oe", 16'h0000, p0_oe);
    @(posedge clk);
    ext_zero_low <= 1'b0;
    dac0_code <= FLPC_DAC_HIGH;
    wr(FLPC_CMD_PINCTL, 16'h00b2);
    idle(2);
    #1;
    chk("pin1 oe", 16'h0000, p1_oe);
    rd(FLPC_CMD_PINCTL, 16'h00f2);
    wr(FLPC_CMD_PINCTL, 16'h00b6);
    idle(2);
    #1;
    chk("pin1 oe", 16'h0001, p1_oe);
    rd(FLPC_CMD_PINCTL, 16'h00d6);
    @(posedge clk);
    dac0_code <= 8'h55;
    dac1_code <= FLPC_DAC_LOW;
    rd(FLPC_CMD_PINCTL, 16'h00d6);
    @(posedge clk);
    dac1_code <= 8'h55;
    rd(FLPC_CMD_PINCTL, 16'h00f6);
    wr(FLPC_CMD_PINCTL, 16'h00be);
    ext_one_low <= 1'b1;
    idle(4);
    rd(FLPC_CMD_PINCTL, 16'h00de);
    @(posedge clk);
    ext_one_low <= 1'b0;
    wr(FLPC_CMD_PINCTL, 16'h008a);
    idle(2);
    #1;
    chk("pin oe", 16'h0003, {p0_oe, p1_oe});
    rd(FLPC_CMD_PINCTL, 16'h00ca);
    wr(FLPC_CMD_PINCTL, 16'h05ba);
    #1;
    chk("launch test", 16'h0003, {trk, adc_test});
    @(posedge clk) tracking_pending <= 1'b1;
    rd(FLPC_CMD_PINCTL, 16'h05fa);
    wr(FLPC_CMD_PINCTL, 16'h008a);
    #1;
    chk("launch test", 16'h0000, {trk, adc_test});
    @(posedge clk);
    strap <= 1'b1;
    arst_n <= 1'b0;
    idle(3);
    arst_n <= 1'b1;
    idle(6);
    #1;
    chk("pin oe", 16'h0003, {p0_oe, p1_oe});
    rd(FLPC_CMD_PINCTL, 16'h06ca);
    close_out();
  end
endmodule // tb_top
